// file: bench/sdbr_burst_read_bench.sv
// Testbench of the SDRAM burst-read port: APB traffic against the SDRAM model.
// Assumes the model's word pattern {5, bank, row, column, 0}.
`timescale 1ns/1ps
`include "sdbr_regs.svh"
module sdbr_burst_read_bench;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        link_clk = 1'b0;
  logic [31:0] sd_dq;
  logic [3:0]  sd_cmd;
  logic [11:0] sd_addr;
  logic [1:0]  sd_bank;
  logic [1:0]  cl_q = 2'h0;
  logic [7:0]  n_rd;
  logic [7:0]  n_ap;
  logic [7:0]  gap;
  logic [7:0]  trail;
  logic        idle;
  logic [31:0] q;
  logic        e;
  int          err_total = 0;
  int          comparisons = 0;

  always #4 clock = ~clock;

  // Offset keeps link edges off the system edges
  initial
  begin
    #3;
    forever #32 link_clk = ~link_clk;
  end

  sdbr_burst_read i_sdbr_burst_read (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_bus_clock(link_clk), .sd_dq(sd_dq),
    .sd_cs_n(sd_cmd[3]), .sd_ras_n(sd_cmd[2]), .sd_cas_n(sd_cmd[1]), .sd_we_n(sd_cmd[0]),
    .sd_addr(sd_addr), .sd_bank(sd_bank));

  sdbr_sdram_model i_sdbr_sdram_model (.link_clk(link_clk), .cmd(sd_cmd), .addr(sd_addr),
    .bank(sd_bank), .cl_sel(cl_q), .dq(sd_dq), .n_rd(n_rd), .n_ap(n_ap), .gap(gap),
    .trail(trail), .idle(idle));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Read data taken at the edge that completes the access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic f);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    r = prdata;
    f = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    logic        f;
    do
      apb(1'b0, `SDBR_OFS_STAT, 32'h0, r, f);
    while (r[b] !== v);
  endtask

  task automatic run(input logic [8:0] cfg, input logic [25:0] a, input logic [1:0] sz);
    logic [31:0] r;
    logic [31:0] w;
    logic        f;
    logic [7:0]  r0;
    logic [7:0]  a0;
    logic [11:0] row;
    logic [10:0] col;
    logic [1:0]  bk;
    int          n;
    int          st;
    cl_q = cfg[5:4];
    apb(1'b1, `SDBR_OFS_CFG, {23'h0, cfg}, r, f);
    apb(1'b1, `SDBR_OFS_ADDR, {6'h0, a}, r, f);
    r0 = n_rd;
    a0 = n_ap;
    apb(1'b1, `SDBR_OFS_CMD, {30'h0, sz}, r, f);
    // Dropped while busy
    apb(1'b1, `SDBR_OFS_CFG, 32'h1ff, r, f);
    st = (cfg[7:6] == 2'b11) ? 4 : 2;
    n = (st == 4) ? ((sz == 2'h3) ? 4 : 1) : ((sz == 2'h3) ? 8 : (sz == 2'h2) ? 2 : 1);
    row = cfg[8] ? a[21:10] : a[20:9];
    bk = cfg[8] ? a[23:22] : a[22:21];
    col = cfg[8] ? a[10:0] : {2'b00, a[8:0]};
    for (int i = 0; i < n; i++)
    begin
      poll(`SDBR_STAT_AVAIL, 1'b1);
      apb(1'b0, `SDBR_OFS_DATA, 32'h0, r, f);
      w = {3'h5, bk, row, col + 11'(i * st), 4'h0};
      chk(r, (st == 2) ? (w & 32'h0000ffff) : w);
    end
    apb(1'b0, `SDBR_OFS_DATA, 32'h0, r, f);
    chk(r, 32'h0);
    poll(`SDBR_STAT_BUSY, 1'b0);
    wait (idle === 1'b1);
    chk({24'h0, n_rd - r0}, 32'(n));
    chk({24'h0, n_ap - a0}, 32'h1);
    chk({24'h0, gap}, {30'h0, cfg[3:2]});
    chk({24'h0, trail}, {30'h0, cfg[1:0]});
    apb(1'b0, `SDBR_OFS_CFG, 32'h0, r, f);
    chk(r, {23'h0, cfg});
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    stop_test();
  end

  initial
  begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, `SDBR_OFS_CFG, 32'h0, q, e);
    chk(q, 32'h80);
    chk({28'h0, sd_cmd}, 32'h0000000f);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    run(9'h015, 26'h12a4a10, 2'h2);
    run(9'h133, 26'h2c53420, 2'h3);
    run(9'h0cc, 26'h0b1e040, 2'h3);
    run(9'h02a, 26'h3f00002, 2'h0);
    run(9'h1c5, 26'h1555008, 2'h1);
    stop_test();
  end
endmodule

// file: bench/sdbr_sdram_model.sv
// SDRAM stand-in: keeps rows per bank, returns reads after the CAS latency.
// Assumes a free-running link clock and a latency select equal to the port's.
`timescale 1ns/1ps
module sdbr_sdram_model (
  input  wire logic        link_clk,
  input  wire logic [3:0]  cmd,
  input  wire logic [11:0] addr,
  input  wire logic [1:0]  bank,
  input  wire logic [1:0]  cl_sel,
  output logic      [31:0] dq,
  output logic      [7:0]  n_rd,
  output logic      [7:0]  n_ap,
  output logic      [7:0]  gap,
  output logic      [7:0]  trail,
  output logic             idle
);
  logic [11:0] row_ff [4];
  logic [32:0] pipe [8];
  logic [7:0]  run;
  logic        rd_seen;
  logic        in_pre;

  initial
  begin
    dq = '0;
    n_rd = '0;
    n_ap = '0;
    gap = '0;
    trail = '0;
    idle = 1'b1;
    run = '0;
    rd_seen = 1'b0;
    in_pre = 1'b0;
    foreach (pipe[i])
      pipe[i] = '0;
  end

  // ******
  // Command decode
  // ******
  always @(posedge link_clk)
  begin
    for (int i = 0; i < 7; i++)
      pipe[i] = pipe[i+1];
    pipe[7] = '0;
    if (cmd != sdbr_pkg::SDBR_CMD_NOP && in_pre)
    begin
      trail = run;
      in_pre = 1'b0;
    end
    idle = (cmd == sdbr_pkg::SDBR_CMD_DESEL);
    if (cmd == sdbr_pkg::SDBR_CMD_NOP)
      run = run + 8'h01;
    if (cmd == sdbr_pkg::SDBR_CMD_ACT)
    begin
      row_ff[bank] = addr;
      run = '0;
      rd_seen = 1'b0;
    end
    if (cmd == sdbr_pkg::SDBR_CMD_RD)
    begin
      if (!rd_seen)
        gap = run;
      rd_seen = 1'b1;
      n_rd = n_rd + 8'h01;
      // Latch stage folded in, so latency zero is served too
      pipe[cl_sel] = {1'b1, 3'h5, bank, row_ff[bank], addr[10:0], 4'h0};
      if (addr[11])
      begin
        n_ap = n_ap + 8'h01;
        in_pre = 1'b1;
        run = '0;
      end
    end
  end

  // Released bus toggles so a stale word never passes
  always @(negedge link_clk)
    dq = pipe[0][32] ? pipe[0][31:0] : ~dq;
endmodule

// file: hw/sdbr_buf.sv
// Two-entry word buffer with valid/ready on both sides.
// Assumes source and sink on the same clock; full shows as up ready low upstream.
`timescale 1ns/1ps
module sdbr_buf (
  input  wire logic clock,
  input  wire logic resetn,
  sdbr_strm_if.snk  up,
  sdbr_strm_if.src  dn
);
  logic [31:0] d0_ff;
  logic [31:0] d1_ff;
  logic [1:0]  cnt_ff;
  logic [31:0] nxt_d0;
  logic [31:0] nxt_d1;
  logic [1:0]  nxt_cnt;
  logic        push;
  logic        pop;

  assign up.ready = (cnt_ff != 2'h2);
  assign dn.valid = (cnt_ff != 2'h0);
  assign dn.data  = d0_ff;
  assign push     = up.valid & up.ready;
  assign pop      = dn.valid & dn.ready;

  always_comb
  begin
    nxt_d0  = d0_ff;
    nxt_d1  = d1_ff;
    nxt_cnt = cnt_ff;
    if (pop)
    begin
      nxt_d0 = d1_ff;
    end
    if (push)
    begin
      if (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop))
        nxt_d0 = up.data;
      else
        nxt_d1 = up.data;
    end
    nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      d0_ff  <= 32'h0;
      d1_ff  <= 32'h0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      d0_ff  <= nxt_d0;
      d1_ff  <= nxt_d1;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// file: hw/sdbr_burst_read.sv
// SDRAM burst-read sequencer with APB registers, staging store and output buffer.
// Assumes the external bus clock and read data pins are asynchronous to clock and
// that the SDRAM clock period spans several system clocks.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sdbr_regs.svh"
module sdbr_burst_read (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_bus_clock,
  input  wire logic [31:0] sd_dq,
  output logic             sd_cs_n,
  output logic             sd_ras_n,
  output logic             sd_cas_n,
  output logic             sd_we_n,
  output logic      [11:0] sd_addr,
  output logic      [1:0]  sd_bank
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [3:0] burst_cnt(input sdbr_pkg::sdbr_size_t sz, input logic wide);
    case (sz)
      sdbr_pkg::SDBR_SZ_LINE: burst_cnt = wide ? 4'h4 : 4'h8;
      sdbr_pkg::SDBR_SZ_LONG: burst_cnt = wide ? 4'h1 : 4'h2;
      default:                burst_cnt = 4'h1;
    endcase
  endfunction

  function automatic logic [11:0] row_of(input logic [`SDBR_ADDR_W-1:0] la, input logic c10);
    row_of = c10 ? la[21:10] : la[20:9];
  endfunction

  function automatic logic [1:0] bank_of(input logic [`SDBR_ADDR_W-1:0] la, input logic c10);
    bank_of = c10 ? la[23:22] : la[22:21];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SDBR_OFS_CFG) || (a == `SDBR_OFS_ADDR) || (a == `SDBR_OFS_CMD) ||
             (a == `SDBR_OFS_STAT) || (a == `SDBR_OFS_DATA);
  endfunction

  // ****************************************
  // Link sampling
  // ****************************************
  logic [32:0] link_s;
  logic        eclk_d_ff;
  logic        nxt_eclk_d;
  logic        evt;

  sdbr_sync #(.W(33)) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      ({external_bus_clock, sd_dq}),
    .q      (link_s)
  );

  assign nxt_eclk_d = link_s[32];
  assign evt        = link_s[32] & ~eclk_d_ff;

  always_ff @(posedge clock)
  begin
    if (!resetn)
      eclk_d_ff <= 1'b0;
    else
      eclk_d_ff <= nxt_eclk_d;
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [`SDBR_CFG_W-1:0]  cfg_ff;
  logic [`SDBR_ADDR_W-1:0] la_ff;
  sdbr_pkg::sdbr_size_t    size_ff;
  logic                    req_ff;
  logic [`SDBR_CFG_W-1:0]  nxt_cfg;
  logic [`SDBR_ADDR_W-1:0] nxt_la;
  sdbr_pkg::sdbr_size_t    nxt_size;
  logic                    nxt_req;

  sdbr_pkg::sdbr_state_t   state_ff;
  sdbr_pkg::sdbr_cmd_t     cmd_ff;
  logic [11:0]             addr_ff;
  logic [1:0]              bank_ff;
  logic [1:0]              cnt_ff;
  logic [3:0]              col_left_ff;
  logic [10:0]             col_ff;
  logic                    first_ff;
  logic [1:0]              pre_bank_ff;
  logic [2:0]              cap_wait_ff;
  logic [3:0]              cap_left_ff;
  sdbr_pkg::sdbr_state_t   nxt_state;
  sdbr_pkg::sdbr_cmd_t     nxt_cmd;
  logic [11:0]             nxt_addr;
  logic [1:0]              nxt_bank;
  logic [1:0]              nxt_cnt;
  logic [3:0]              nxt_col_left;
  logic [10:0]             nxt_col;
  logic                    nxt_first;
  logic [1:0]              nxt_pre_bank;
  logic [2:0]              nxt_cap_wait;
  logic [3:0]              nxt_cap_left;

  logic [31:0]             stg_ff [`SDBR_STG_DEPTH];
  logic [2:0]              stg_wr_ff;
  logic [2:0]              stg_rd_ff;
  logic [3:0]              stg_cnt_ff;
  logic [31:0]             nxt_stg [`SDBR_STG_DEPTH];
  logic [2:0]              nxt_stg_wr;
  logic [2:0]              nxt_stg_rd;
  logic [3:0]              nxt_stg_cnt;

  logic                    wide;
  logic                    col10;
  logic                    busy;
  logic                    start_ok;
  logic                    start;
  logic                    cap_fire;
  logic                    acc;
  logic                    pop_stg;
  logic                    rd_data;

  sdbr_strm_if stg_if ();
  sdbr_strm_if out_if ();

  sdbr_buf u_buf (
    .clock  (clock),
    .resetn (resetn),
    .up     (stg_if.snk),
    .dn     (out_if.src)
  );

  assign wide     = (cfg_ff[`SDBR_CFG_BSZ] == `SDBR_BSZ_32);
  assign col10    = cfg_ff[`SDBR_CFG_COL10];
  assign busy     = (state_ff != sdbr_pkg::SDBR_ST_IDLE) || req_ff || (cap_left_ff != 4'h0);
  // A new access waits until the previous one is fully drained from staging
  assign start_ok = req_ff && (stg_cnt_ff == 4'h0) && (cap_left_ff == 4'h0);

  // ****************************************
  // APB slave
  // ****************************************
  assign acc     = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped(paddr);
  assign rd_data = acc & ~pwrite & (paddr == `SDBR_OFS_DATA);
  assign out_if.ready = rd_data;

  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      `SDBR_OFS_CFG:  prdata = {23'h0, cfg_ff};
      `SDBR_OFS_ADDR: prdata = {6'h0, la_ff};
      `SDBR_OFS_CMD:  prdata = {30'h0, size_ff};
      `SDBR_OFS_STAT: prdata = {24'h0, stg_cnt_ff, 2'h0, out_if.valid, busy};
      `SDBR_OFS_DATA: prdata = out_if.valid ? out_if.data : 32'h0;
      default:        prdata = 32'h0;
    endcase
  end

  always_comb
  begin
    nxt_cfg  = cfg_ff;
    nxt_la   = la_ff;
    nxt_size = size_ff;
    nxt_req  = start ? 1'b0 : req_ff;
    // Settings are frozen while an access is in flight
    if (acc && pwrite && !busy)
    begin
      case (paddr)
        `SDBR_OFS_CFG:  nxt_cfg = pwdata[`SDBR_CFG_W-1:0];
        `SDBR_OFS_ADDR: nxt_la  = pwdata[`SDBR_ADDR_W-1:0];
        `SDBR_OFS_CMD:
        begin
          nxt_size = sdbr_pkg::sdbr_size_t'(pwdata[`SDBR_CMD_SIZE]);
          nxt_req  = 1'b1;
        end
        default: nxt_req = nxt_req;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cfg_ff  <= `SDBR_CFG_RST;
      la_ff   <= '0;
      size_ff <= sdbr_pkg::SDBR_SZ_BYTE;
      req_ff  <= 1'b0;
    end
    else
    begin
      cfg_ff  <= nxt_cfg;
      la_ff   <= nxt_la;
      size_ff <= nxt_size;
      req_ff  <= nxt_req;
    end
  end

  // ****************************************
  // Command sequencer and capture timing
  // ****************************************
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cmd      = cmd_ff;
    nxt_addr     = addr_ff;
    nxt_bank     = bank_ff;
    nxt_cnt      = cnt_ff;
    nxt_col_left = col_left_ff;
    nxt_col      = col_ff;
    nxt_first    = first_ff;
    nxt_pre_bank = pre_bank_ff;
    nxt_cap_wait = cap_wait_ff;
    nxt_cap_left = cap_left_ff;
    start        = 1'b0;
    cap_fire     = 1'b0;
    if (evt)
    begin
      if (cap_wait_ff > 3'h1)
        nxt_cap_wait = cap_wait_ff - 3'h1;
      else if (cap_wait_ff == 3'h1 && cap_left_ff != 4'h0)
      begin
        cap_fire     = 1'b1;
        nxt_cap_left = cap_left_ff - 4'h1;
        if (cap_left_ff == 4'h1)
          nxt_cap_wait = 3'h0;
      end
      nxt_cmd = (state_ff == sdbr_pkg::SDBR_ST_IDLE) ? sdbr_pkg::SDBR_CMD_DESEL :
                                                       sdbr_pkg::SDBR_CMD_NOP;
      case (state_ff)
        sdbr_pkg::SDBR_ST_RWAIT:
        begin
          nxt_cnt = cnt_ff - 2'h1;
          if (cnt_ff == 2'h1)
            nxt_state = sdbr_pkg::SDBR_ST_COL;
        end
        sdbr_pkg::SDBR_ST_COL:
        begin
          nxt_cmd      = sdbr_pkg::SDBR_CMD_RD;
          nxt_addr     = {col_left_ff == 4'h1, col_ff};
          nxt_col      = col_ff + (wide ? 11'h004 : 11'h002);
          nxt_col_left = col_left_ff - 4'h1;
          nxt_first    = 1'b0;
          if (first_ff)
          begin
            // Latency counted from the link edge that issues the first read, one before the SDRAM takes it
            nxt_cap_wait = 3'(cfg_ff[`SDBR_CFG_CL]) + 3'h2;
            nxt_cap_left = burst_cnt(size_ff, wide);
          end
          if (col_left_ff == 4'h1)
          begin
            nxt_pre_bank = bank_ff;
            nxt_cnt      = cfg_ff[`SDBR_CFG_TRP];
            nxt_state    = (cfg_ff[`SDBR_CFG_TRP] == 2'h0) ? sdbr_pkg::SDBR_ST_IDLE :
                                                             sdbr_pkg::SDBR_ST_PRE;
          end
        end
        sdbr_pkg::SDBR_ST_PRE:
        begin
          nxt_cnt = cnt_ff - 2'h1;
          if (cnt_ff == 2'h1)
            nxt_state = sdbr_pkg::SDBR_ST_IDLE;
        end
        default: nxt_state = nxt_state;
      endcase
      // The precharge branch never fires: busy refuses command writes until idle, so a pending request always starts from idle
      if (start_ok && (state_ff == sdbr_pkg::SDBR_ST_IDLE ||
          (state_ff == sdbr_pkg::SDBR_ST_PRE && bank_of(la_ff, col10) != pre_bank_ff)))
      begin
        start        = 1'b1;
        nxt_cmd      = sdbr_pkg::SDBR_CMD_ACT;
        nxt_addr     = row_of(la_ff, col10);
        nxt_bank     = bank_of(la_ff, col10);
        nxt_col      = col10 ? la_ff[10:0] : {2'h0, la_ff[8:0]};
        nxt_col_left = burst_cnt(size_ff, wide);
        nxt_first    = 1'b1;
        nxt_cnt      = cfg_ff[`SDBR_CFG_TRCD];
        nxt_state    = (cfg_ff[`SDBR_CFG_TRCD] == 2'h0) ? sdbr_pkg::SDBR_ST_COL :
                                                         sdbr_pkg::SDBR_ST_RWAIT;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_ff    <= sdbr_pkg::SDBR_ST_IDLE;
      cmd_ff      <= sdbr_pkg::SDBR_CMD_DESEL;
      addr_ff     <= 12'h000;
      bank_ff     <= 2'h0;
      cnt_ff      <= 2'h0;
      col_left_ff <= 4'h0;
      col_ff      <= 11'h000;
      first_ff    <= 1'b0;
      pre_bank_ff <= 2'h0;
      cap_wait_ff <= 3'h0;
      cap_left_ff <= 4'h0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cmd_ff      <= nxt_cmd;
      addr_ff     <= nxt_addr;
      bank_ff     <= nxt_bank;
      cnt_ff      <= nxt_cnt;
      col_left_ff <= nxt_col_left;
      col_ff      <= nxt_col;
      first_ff    <= nxt_first;
      pre_bank_ff <= nxt_pre_bank;
      cap_wait_ff <= nxt_cap_wait;
      cap_left_ff <= nxt_cap_left;
    end
  end

  assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_ff;
  assign sd_addr = addr_ff;
  assign sd_bank = bank_ff;

  // ****************************************
  // Staging store
  // ****************************************
  // Holds a whole access, since SDRAM data cannot be paused mid-burst
  assign stg_if.valid = (stg_cnt_ff != 4'h0);
  assign stg_if.data  = stg_ff[stg_rd_ff];
  assign pop_stg      = stg_if.valid & stg_if.ready;

  always_comb
  begin
    nxt_stg     = stg_ff;
    nxt_stg_wr  = stg_wr_ff;
    nxt_stg_rd  = stg_rd_ff;
    if (cap_fire)
    begin
      nxt_stg[stg_wr_ff] = wide ? link_s[31:0] : {16'h0, link_s[15:0]};
      nxt_stg_wr         = stg_wr_ff + 3'h1;
    end
    if (pop_stg)
      nxt_stg_rd = stg_rd_ff + 3'h1;
    nxt_stg_cnt = 4'(stg_cnt_ff + {3'h0, cap_fire} - {3'h0, pop_stg});
  end

  always_ff @(posedge clock)
  begin
    stg_ff <= nxt_stg;
    if (!resetn)
    begin
      stg_wr_ff  <= 3'h0;
      stg_rd_ff  <= 3'h0;
      stg_cnt_ff <= 4'h0;
    end
    else
    begin
      stg_wr_ff  <= nxt_stg_wr;
      stg_rd_ff  <= nxt_stg_rd;
      stg_cnt_ff <= nxt_stg_cnt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_row_addr;
    start |=> (cmd_ff == sdbr_pkg::SDBR_CMD_ACT) && (sd_addr == row_of($past(la_ff), col10));
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address wrong");

  property p_ap_pin;
    (evt && state_ff == sdbr_pkg::SDBR_ST_COL) |=>
      (sd_addr[`SDBR_AP_PIN] == ($past(col_left_ff) == 4'h1));
  endproperty
  a_ap_pin: assert property (p_ap_pin) else $error("precharge pin wrong");

  property p_bursts;
    start |=> col_left_ff == ((size_ff == sdbr_pkg::SDBR_SZ_LINE) ? (wide ? 4'h4 : 4'h8) :
                              (size_ff == sdbr_pkg::SDBR_SZ_LONG && !wide) ? 4'h2 : 4'h1);
  endproperty
  a_bursts: assert property (p_bursts) else $error("burst count wrong");

  property p_last_read;
    (evt && state_ff == sdbr_pkg::SDBR_ST_COL && col_left_ff == 4'h1) |=>
      (cmd_ff == sdbr_pkg::SDBR_CMD_RD) && sd_addr[`SDBR_AP_PIN] &&
      (state_ff != sdbr_pkg::SDBR_ST_COL);
  endproperty
  a_last_read: assert property (p_last_read) else $error("auto-precharge read missing");

  property p_pre_bank;
    (evt && state_ff == sdbr_pkg::SDBR_ST_PRE && bank_of(la_ff, col10) == pre_bank_ff) |=>
      (cmd_ff == sdbr_pkg::SDBR_CMD_NOP);
  endproperty
  a_pre_bank: assert property (p_pre_bank) else $error("command to precharging bank");

  property p_trp;
    (evt && state_ff == sdbr_pkg::SDBR_ST_COL && col_left_ff == 4'h1 && !start) |=>
      (cnt_ff == cfg_ff[`SDBR_CFG_TRP]);
  endproperty
  a_trp: assert property (p_trp) else $error("precharge wait count wrong");

  property p_trcd;
    (start && cfg_ff[`SDBR_CFG_TRCD] != 2'h0) |=>
      (state_ff == sdbr_pkg::SDBR_ST_RWAIT) && (cnt_ff == $past(cfg_ff[`SDBR_CFG_TRCD]));
  endproperty
  a_trcd: assert property (p_trcd) else $error("activate-to-read count wrong");

  property p_rwait_nop;
    (evt && state_ff == sdbr_pkg::SDBR_ST_RWAIT) |=> (cmd_ff == sdbr_pkg::SDBR_CMD_NOP);
  endproperty
  a_rwait_nop: assert property (p_rwait_nop) else $error("wait cycle not a nop");

  property p_cas;
    (evt && state_ff == sdbr_pkg::SDBR_ST_COL && first_ff) |=>
      (cap_wait_ff == 3'(cfg_ff[`SDBR_CFG_CL]) + 3'h2);
  endproperty
  a_cas: assert property (p_cas) else $error("cas latency wrong");

  // Pins still hold the previous read's column when the next one is decided
  property p_col_next;
    (evt && state_ff == sdbr_pkg::SDBR_ST_COL && !first_ff) |=>
      (sd_addr[10:0] == $past(sd_addr[10:0]) + (wide ? 11'h004 : 11'h002));
  endproperty
  a_col_next: assert property (p_col_next) else $error("column not sequential");

  c_line16: cover property (start && size_ff == sdbr_pkg::SDBR_SZ_LINE && !wide);
  c_waits: cover property (start && cfg_ff[`SDBR_CFG_TRCD] != 2'h0);
  c_other_bank: cover property (start && state_ff == sdbr_pkg::SDBR_ST_PRE);
  c_full: cover property (stg_if.valid && !stg_if.ready);
endmodule

// file: hw/sdbr_pkg.sv
// Types shared by the SDRAM burst-read port modules.
// Assumes the constants header sits beside it.
package sdbr_pkg;

  typedef enum logic [1:0] {
    SDBR_ST_IDLE  = 2'b00,
    SDBR_ST_RWAIT = 2'b01,
    SDBR_ST_COL   = 2'b10,
    SDBR_ST_PRE   = 2'b11
  } sdbr_state_t;

  // {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDBR_CMD_DESEL = 4'hf,
    SDBR_CMD_NOP   = 4'h7,
    SDBR_CMD_ACT   = 4'h3,
    SDBR_CMD_RD    = 4'h5
  } sdbr_cmd_t;

  typedef enum logic [1:0] {
    SDBR_SZ_BYTE = 2'b00,
    SDBR_SZ_WORD = 2'b01,
    SDBR_SZ_LONG = 2'b10,
    SDBR_SZ_LINE = 2'b11
  } sdbr_size_t;

endpackage

// file: hw/sdbr_regs.svh
// Register offsets, field positions, reset values and counts of the SDRAM burst-read port.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef SDBR_REGS_SVH
`define SDBR_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SDBR_OFS_CFG    8'h00
`define SDBR_OFS_ADDR   8'h04
`define SDBR_OFS_CMD    8'h08
`define SDBR_OFS_STAT   8'h0c
`define SDBR_OFS_DATA   8'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define SDBR_CFG_TRP    1:0
`define SDBR_CFG_TRCD   3:2
`define SDBR_CFG_CL     5:4
`define SDBR_CFG_BSZ    7:6
`define SDBR_CFG_COL10  8
`define SDBR_CFG_W      9
`define SDBR_CFG_RST    9'h080
`define SDBR_BSZ_32     2'h3
`define SDBR_ADDR_W     26
`define SDBR_CMD_SIZE   1:0
`define SDBR_STAT_BUSY  0
`define SDBR_STAT_AVAIL 1
`define SDBR_STAT_LVL   7:4
`define SDBR_AP_PIN     11
`define SDBR_STG_DEPTH  8

`endif

// file: hw/sdbr_strm_if.sv
// Valid/ready word stream between the port's own modules.
// Assumes one source and one sink on the same clock.
`timescale 1ns/1ps
interface sdbr_strm_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hw/sdbr_sync.sv
// Two-flop synchroniser for pins from the external bus clock domain.
// Assumes the pins are quasi-static over several system clocks.
`timescale 1ns/1ps
module sdbr_sync #(
  parameter int W = 33
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;

  always_comb
  begin
    nxt_s1 = d;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  assign q = s2_ff;
endmodule
